// >>> tb/testbench.sv
// self-checking bench for the usart based spi master
`timescale 1ns/100ps
`include "usm_spi_defines.svh"

module testbench;
   localparam logic [7:0] A_DAT = `USM_OFS_DATA;
   localparam logic [7:0] A_ST  = `USM_OFS_STATUS;
   localparam logic [7:0] A_CT  = `USM_OFS_CONTROL;
   logic        clk, rstn, psel, pen, pwr, pready, slverr, se, sdi, sel;
   logic        sdo, sdo_oe, xck, xck_oe, gie, ack, lsb;
   logic [1:0]  md;
   logic [2:0]  irq;
   logic [7:0]  paddr, got, b;
   logic [31:0] pwdata, prdata, q;
   int          n_mismatch, num_checks, cyc, k, ne;
   time         t0, t1;

   usm_spi_top u_dut
   (
      .CLOCK_I (clk), .RSTN_I (rstn), .PSEL_I (psel), .PENABLE_I (pen),
      .PWRITE_I (pwr), .PADDR_I (paddr), .PWDATA_I (pwdata), .PRDATA_O (prdata),
      .PREADY_O (pready), .PSLVERR_O (slverr), .SDI_I (sdi), .SDI_SEL_O (sel),
      .SDO_O (sdo), .SDO_OE_O (sdo_oe), .XCK_O (xck), .XCK_OE_O (xck_oe),
      .GLOBAL_IE_I (gie), .TXC_ACK_I (ack), .IRQ_RXC_O (irq[2]),
      .IRQ_TXC_O (irq[1]), .IRQ_UDRE_O (irq[0])
   );

   usm_spi_slave u_slave
   (
      .rstn_i (rstn), .xck_i (xck), .xck_oe_i (xck_oe), .sdo_i (sdo),
      .mode_i (md), .lsb_i (lsb), .sdi_o (sdi), .got_o (got)
   );

   // ------------------------------------------
   // bus tasks and checks
   // ------------------------------------------
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel   <= 1'b1;
      pen    <= 1'b0;
      pwr    <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
         @(posedge clk);
      q  = prdata;
      se = slverr;
      psel <= 1'b0;
      pen  <= 1'b0;
   endtask : apb

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e)
      begin
         $display("wrong value %s expected %h seen %h", n, e, g);
         n_mismatch++;
      end
   endtask : chk

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
      apb(1'b0, a, 32'h0);
      chk(n, e, q);
   endtask : rd

   task automatic wait_st(input logic [7:0] m);
      do
         apb(1'b0, A_ST, 32'h0);
      while ((q[7:0] & m) !== m);
   endtask : wait_st

   function automatic logic [7:0] ans(input int n);
      return 8'(8'h5A + 8'h13 * n);
   endfunction : ans

   task automatic results;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : results

   // clock, hang guard and link edge log
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_mismatch++;
         results();
      end
   end

   always @(xck)
   begin
      if (ne == 0)
         t0 = $time;
      t1 = $time;
      ne++;
   end

   // ------------------------------------------
   // main sequence
   // ------------------------------------------
   initial
   begin
      {rstn, psel, pen, pwr, gie, ack, lsb, md, paddr, pwdata} = '0;
      k = 0;
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      ne = 0;
      rd(A_ST, 32'h20, "status reset");
      rd(A_CT, 32'h00, "control reset");
      rd(`USM_OFS_MODE, 32'h06, "mode reset");
      rd(`USM_OFS_BAUD, 32'h00, "baud reset");
      rd(8'h14, 32'h00, "unmapped read");
      chk("unmapped error", 32'h1, {31'h0, se});
      apb(1'b1, A_CT, 32'h18);
      apb(1'b1, A_DAT, 32'hC3);
      repeat (20) @(posedge clk);
      rd(A_ST, 32'h20, "no frame outside spi");
      chk("idle clock", 32'h0, 32'(ne));
      for (int m = 0; m < 5; m++)
      begin
         md  <= (m < 2) ? 2'b00 : 2'(m - 1);
         lsb <= (m == 1);
         b = 8'(8'hB4 + 37 * m);
         apb(1'b1, A_CT, 32'h00);
         apb(1'b1, `USM_OFS_BAUD, 32'h00);
         apb(1'b1, `USM_OFS_MODE, {24'h0, 2'b11, 3'b000, lsb, md});
         apb(1'b1, A_CT, 32'h18);
         apb(1'b1, `USM_OFS_BAUD, 32'h03);
         @(negedge clk);
         chk("pin enables", 32'h7, {29'h0, sel, sdo_oe, xck_oe});
         apb(1'b1, A_DAT, {24'h0, b});
         wait_st(8'hC0);
         rd(A_DAT, {24'h0, ans(k)}, "reply byte");
         chk("slave byte", {24'h0, b}, {24'h0, got});
         rd(A_ST, 32'h60, "status after frame");
         apb(1'b1, A_ST, 32'h40);
         rd(A_ST, 32'h20, "status cleared");
         k++;
      end
      ne = 0;
      for (int i = 0; i < 3; i++)
      begin
         wait_st(8'h20);
         apb(1'b1, A_DAT, 32'(8'h10 + i));
      end
      wait_st(8'h40);
      chk("edge count", 32'd48, 32'(ne));
      chk("edge span", 32'd3760, 32'(t1 - t0));
      rd(A_DAT, {24'h0, ans(k)}, "oldest byte");
      rd(A_DAT, {24'h0, ans(k + 1)}, "second byte");
      rd(A_ST, 32'h60, "newest dropped");
      apb(1'b1, A_ST, 32'h40);
      apb(1'b1, A_CT, 32'hF8);
      gie <= 1'b1;
      apb(1'b1, A_DAT, 32'h5C);
      wait_st(8'hC0);
      rd(A_ST, 32'hE0, "status with requests");
      @(negedge clk);
      chk("requests", 32'h7, {29'h0, irq});
      @(posedge clk);
      gie <= 1'b0;
      @(negedge clk);
      chk("requests masked", 32'h0, {29'h0, irq});
      @(posedge clk);
      gie <= 1'b1;
      ack <= 1'b1;
      @(posedge clk);
      ack <= 1'b0;
      @(negedge clk);
      chk("ack clears", 32'h5, {29'h0, irq});
      apb(1'b1, A_CT, 32'hE8);
      @(negedge clk);
      chk("rx released", 32'h0, {31'h0, sel});
      rd(A_ST, 32'h20, "flushed");
      results();
   end
endmodule : testbench

// >>> tb/usm_spi_checker.sv
// port assertions for the usart based spi master
`timescale 1ns/100ps
`include "usm_spi_defines.svh"

module usm_spi_checker
(
   // clock, reset and bus
   input  wire logic        CLOCK_I,
   input  wire logic        RSTN_I,
   input  wire logic        PSEL_I,
   input  wire logic        PENABLE_I,
   input  wire logic        PWRITE_I,
   input  wire logic [7:0]  PADDR_I,
   input  wire logic [31:0] PRDATA_O,
   // serial pins
   input  wire logic        SDI_SEL_O,
   input  wire logic        SDO_O,
   input  wire logic        SDO_OE_O,
   input  wire logic        XCK_O,
   input  wire logic        XCK_OE_O,
   // requests
   input  wire logic        GLOBAL_IE_I,
   input  wire logic        TXC_ACK_I,
   input  wire logic        IRQ_RXC_O,
   input  wire logic        IRQ_TXC_O,
   input  wire logic        IRQ_UDRE_O
);
   // ------------------------------------------
   // properties
   // ------------------------------------------
   default clocking @(posedge CLOCK_I); endclocking
   default disable iff (!RSTN_I);
   logic st_rd;

   // setup cycle of a status read
   assign st_rd = PSEL_I && !PENABLE_I && !PWRITE_I && (PADDR_I == `USM_OFS_STATUS);

   property p_sdo_idle; !SDO_OE_O |-> SDO_O; endproperty
   property p_xck_oe; $changed(XCK_O) && SDO_OE_O |-> XCK_OE_O; endproperty
   property p_rx_flush; !SDI_SEL_O ##1 !SDI_SEL_O |-> !IRQ_RXC_O; endproperty
   property p_txc_ack; TXC_ACK_I |=> !IRQ_TXC_O || $changed(XCK_O); endproperty
   property p_st_rsv; st_rd |=> PRDATA_O[4:0] == 5'h00 && PRDATA_O[31:8] == 24'h000000;
   endproperty
   property p_irq_rxc; st_rd && IRQ_RXC_O |=> PRDATA_O[7]; endproperty
   property p_irq_txc; st_rd && IRQ_TXC_O |=> PRDATA_O[6]; endproperty
   property p_irq_udre; st_rd && IRQ_UDRE_O |=> PRDATA_O[5]; endproperty
   property p_no_gie; !GLOBAL_IE_I |-> !(IRQ_RXC_O || IRQ_TXC_O || IRQ_UDRE_O); endproperty

   a_sdo_idle: assert property (p_sdo_idle) else $error("serial out not idle");
   a_xck_oe: assert property (p_xck_oe) else $error("clock enable differs");
   a_rx_flush: assert property (p_rx_flush) else $error("rx flag kept");
   a_txc_ack: assert property (p_txc_ack) else $error("tx flag kept");
   a_st_rsv: assert property (p_st_rsv) else $error("status spare bits set");
   a_irq_rxc: assert property (p_irq_rxc) else $error("rx request no flag");
   a_irq_txc: assert property (p_irq_txc) else $error("tx request no flag");
   a_irq_udre: assert property (p_irq_udre) else $error("empty request no flag");
   a_no_gie: assert property (p_no_gie) else $error("request while masked");

   // main scenarios reached
   c_xck: cover property ($changed(XCK_O));
   c_ack: cover property (IRQ_TXC_O ##1 !IRQ_TXC_O);
   c_rd: cover property (st_rd && IRQ_RXC_O);
endmodule : usm_spi_checker

bind usm_spi_top usm_spi_checker u_chk (.*);

// >>> tb/usm_spi_slave.sv
// behavioural spi slave facing the master
`timescale 1ns/100ps

module usm_spi_slave
(
   // master pins
   input  wire logic       rstn_i,
   input  wire logic       xck_i,
   input  wire logic       xck_oe_i,
   input  wire logic       sdo_i,
   // link settings, cpha then cpol
   input  wire logic [1:0] mode_i,
   input  wire logic       lsb_i,
   // answer and capture
   output logic            sdi_o,
   output logic [7:0]      got_o
);
   logic [7:0] sh;
   logic [7:0] nf;
   logic [2:0] c;

   // reply depends only on the frame count
   function automatic logic [7:0] reply(input logic [7:0] n);
      return 8'h5A + 8'h13 * n;
   endfunction : reply

   assign sdi_o = lsb_i ? sh[0] : sh[7];

   // setup edges move the reply, sample edges take serial out
   always @(xck_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         c  = 3'h0;
         nf = 8'h00;
         sh = reply(8'h00);
      end
      else if (xck_oe_i && ((xck_i != mode_i[0]) == mode_i[1]))
      begin
         if (c == 3'h0)
            sh = reply(nf);
         else
            sh = lsb_i ? sh >> 1 : sh << 1;
      end
      else if (xck_oe_i)
      begin
         got_o = lsb_i ? {sdo_i, got_o[7:1]} : {got_o[6:0], sdo_i};
         c     = c + 3'h1;
         if (c == 3'h0)
            nf = nf + 8'h01;
      end
   end
endmodule : usm_spi_slave

// >>> verilog/usm_spi_defines.svh
// register offsets, field positions and reset values of the spi master
`ifndef USM_SPI_DEFINES_SVH
`define USM_SPI_DEFINES_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define USM_OFS_DATA     8'h00
`define USM_OFS_STATUS   8'h04
`define USM_OFS_CONTROL  8'h08
`define USM_OFS_MODE     8'h0C
`define USM_OFS_BAUD     8'h10

// ------------------------------------------------------------
// status field positions
// ------------------------------------------------------------
`define USM_ST_RXC       7
`define USM_ST_TXC       6
`define USM_ST_UDRE      5

// ------------------------------------------------------------
// control field positions
// ------------------------------------------------------------
`define USM_CT_RXCIE     7
`define USM_CT_TXCIE     6
`define USM_CT_TX_EMPTY_IRQ_ENABLE     5
`define USM_CT_RXEN      4
`define USM_CT_TXEN      3

// ------------------------------------------------------------
// mode field positions
// ------------------------------------------------------------
`define USM_MD_SEL_HI    7
`define USM_MD_SEL_LO    6
`define USM_MD_ORDER     2
`define USM_MD_CPHA      1
`define USM_MD_CPOL      0

// ------------------------------------------------------------
// reset values and counts
// ------------------------------------------------------------
`define USM_RST_CONTROL  8'h00
`define USM_RST_MODE     8'h06
`define USM_RST_BAUD     12'h000
`define USM_MSPI_SEL     2'h3
`define USM_LAST_EDGE    4'hF
`define USM_RX_DEPTH     2'h2

`endif

// >>> verilog/usm_spi_pkg.sv
// types shared by the spi master
package usm_spi_pkg;

   // ---------------------------------------------------------
   // engine phases
   // ---------------------------------------------------------
   typedef enum logic {USM_IDLE, USM_SHIFT} usm_phase_type;

   // ---------------------------------------------------------
   // whole module state
   // ---------------------------------------------------------
   typedef struct packed {
      usm_phase_type phase;
      logic [7:0]    control;
      logic [7:0]    mode;
      logic [11:0]   baud;
      logic [11:0]   div;
      logic [3:0]    half;
      logic [7:0]    txbuf;
      logic          txfull;
      logic [7:0]    tsr;
      logic [7:0]    rsr;
      logic [7:0]    rx0;
      logic [7:0]    rx1;
      logic [1:0]    rxcnt;
      logic          txc;
      logic          sck;
      logic          sdo;
      logic [1:0]    sdi_sync;
      logic [31:0]   prdata;
   } usm_state_type;

endpackage : usm_spi_pkg

// >>> verilog/usm_spi_top.sv
// usart based spi master with apb registers
//
// How it works
// - transmitter enable runs spi, drives serial out
// - optional receiver takes serial in pin
// - transfer clock pin driven only with the transmitter on, in spi mode
// - data register write starts each transfer
// - buffer moves to shifter once it frees
// - overflow drops newest byte, keeps older
// - frame, overrun, parity flags read zero
// - double transmit buffer, two-level receive buffer
// - no collision flag, no double speed
// - master only, no slave select input
// - polarity, phase, order as standard spi
// - receive flag tracks buffer, flush on disable
// - transmit flag sets when all sent
// - transmit flag cleared by acknowledge or one
// - empty flag high when buffer free, reset
// - empty flag can raise interrupt request
// - receive irq needs enable, global, flag
// - transmit irq needs enable, global, flag
// - both mode bits set select spi master
// - eight bit frames, msb or lsb first
// - setup and sample on opposite clock edges
// - empty irq enable with global flag set
//
// Our own choices: register access over APB and the address map.
`timescale 1ns/100ps
`include "usm_spi_defines.svh"

module usm_spi_top
(
   // clock and reset
   input  wire logic        CLOCK_I,
   input  wire logic        RSTN_I,
   // apb slave
   input  wire logic        PSEL_I,
   input  wire logic        PENABLE_I,
   input  wire logic        PWRITE_I,
   input  wire logic [7:0]  PADDR_I,
   input  wire logic [31:0] PWDATA_I,
   output logic      [31:0] PRDATA_O,
   output logic             PREADY_O,
   output logic             PSLVERR_O,
   // serial pins
   input  wire logic        SDI_I,
   output logic             SDI_SEL_O,
   output logic             SDO_O,
   output logic             SDO_OE_O,
   output logic             XCK_O,
   output logic             XCK_OE_O,
   // interrupt requests
   input  wire logic        GLOBAL_IE_I,
   input  wire logic        TXC_ACK_I,
   output logic             IRQ_RXC_O,
   output logic             IRQ_TXC_O,
   output logic             IRQ_UDRE_O
);

   // ---------------------------------------------------------
   // helpers
   // ---------------------------------------------------------

   // bit that leaves the shifter next
   function automatic logic pick_bit(input logic [7:0] sr, input logic lsb);
      pick_bit = lsb ? sr[0] : sr[7];
   endfunction : pick_bit

   // shifter after one bit has left
   function automatic logic [7:0] drop_bit(input logic [7:0] sr,
                                           input logic lsb);
      drop_bit = lsb ? {1'b0, sr[7:1]} : {sr[6:0], 1'b0};
   endfunction : drop_bit

   // address decode for reads and writes
   function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
      hit = (a == o);
   endfunction : hit

   // ---------------------------------------------------------
   // state
   // ---------------------------------------------------------
   usm_spi_pkg::usm_state_type s_reg;
   usm_spi_pkg::usm_state_type s_next;

   logic       spi_on;
   logic       txen_eff;
   logic       mapped;
   logic       acc;
   logic [7:0] stat;

   // mode and deferred transmitter disable
   // a cleared transmit enable keeps the pins driven
   // until the shifter and the buffer have drained,
   // so a queued byte is never cut off mid frame
   assign spi_on   = (s_reg.mode[`USM_MD_SEL_HI:`USM_MD_SEL_LO]
                      == `USM_MSPI_SEL);
   assign txen_eff = s_reg.control[`USM_CT_TXEN] | s_reg.txfull
                     | (s_reg.phase == usm_spi_pkg::USM_SHIFT);
   assign acc      = PSEL_I & PENABLE_I;
   assign mapped   = hit(PADDR_I, `USM_OFS_DATA)
                     | hit(PADDR_I, `USM_OFS_STATUS)
                     | hit(PADDR_I, `USM_OFS_CONTROL)
                     | hit(PADDR_I, `USM_OFS_MODE)
                     | hit(PADDR_I, `USM_OFS_BAUD);

   // status image, error flags and low bits zero
   // error flags do not exist in this mode, so the
   // frame, overrun and parity positions read zero
   always_comb
   begin
      stat                = 8'h00;
      stat[`USM_ST_RXC]   = (s_reg.rxcnt != 2'h0);
      stat[`USM_ST_TXC]   = s_reg.txc;
      stat[`USM_ST_UDRE]  = ~s_reg.txfull;
   end

   // ---------------------------------------------------------
   // next state
   // ---------------------------------------------------------
   always_comb
   begin
      logic       lsb;
      logic       cpha;
      logic       lead;
      logic       rx_push;
      logic       load;
      logic       set_txc;
      logic [1:0] cnt;
      logic [7:0] word;

      s_next   = s_reg;
      lsb      = s_reg.mode[`USM_MD_ORDER];
      cpha     = s_reg.mode[`USM_MD_CPHA];
      lead     = ~s_reg.half[0];
      rx_push  = 1'b0;
      load     = 1'b0;
      set_txc  = 1'b0;
      cnt      = s_reg.rxcnt;
      word     = s_reg.rsr;

      // two-flop input synchroniser
      s_next.sdi_sync = {s_reg.sdi_sync[0], SDI_I};

      // read data captured in setup phase
      // capturing here lets PRDATA come straight from a
      // flop while the access phase ends with no wait
      if (PSEL_I && !PENABLE_I)
      begin
         case (PADDR_I)
            `USM_OFS_DATA:    s_next.prdata = {24'h000000, s_reg.rx0};
            `USM_OFS_STATUS:  s_next.prdata = {24'h000000, stat};
            `USM_OFS_CONTROL: s_next.prdata = {24'h000000, s_reg.control};
            `USM_OFS_MODE:    s_next.prdata = {24'h000000, s_reg.mode};
            `USM_OFS_BAUD:    s_next.prdata = {20'h00000, s_reg.baud};
            default:          s_next.prdata = 32'h00000000;
         endcase
      end

      // register writes
      // spare control and mode bits are stored as zero
      // so that they always read back as zero
      if (acc && PWRITE_I)
      begin
         if (hit(PADDR_I, `USM_OFS_CONTROL))
            s_next.control = {PWDATA_I[7:3], 3'h0};
         if (hit(PADDR_I, `USM_OFS_MODE))
            s_next.mode = {PWDATA_I[7:6], 3'h0, PWDATA_I[2:0]};
         if (hit(PADDR_I, `USM_OFS_BAUD))
            s_next.baud = PWDATA_I[11:0];
         // write one clears transmit complete
         if (hit(PADDR_I, `USM_OFS_STATUS) && PWDATA_I[`USM_ST_TXC])
            s_next.txc = 1'b0;
         // data write fills the transmit buffer
         // a write that finds the buffer full is dropped,
         // software polls the empty flag first
         if (hit(PADDR_I, `USM_OFS_DATA) && spi_on && !s_reg.txfull
             && s_reg.control[`USM_CT_TXEN])
         begin
            s_next.txbuf  = PWDATA_I[7:0];
            s_next.txfull = 1'b1;
         end
      end
      if (TXC_ACK_I)
         s_next.txc = 1'b0;

      // bit engine, baud divider paces each half period
      // a half period lasts baud plus one clocks and the
      // toggle appears on the pin one clock after div
      // reaches zero; the sampled input lags the pin by
      // two clocks through the synchroniser, so a slave
      // must hold its bit three clocks past its edge,
      // which a baud of zero or one does not leave
      case (s_reg.phase)
         usm_spi_pkg::USM_IDLE:
         begin
            s_next.sck = s_reg.mode[`USM_MD_CPOL];
            s_next.sdo = 1'b1;
            load       = 1'b1;
         end
         usm_spi_pkg::USM_SHIFT:
         begin
            if (s_reg.div != 12'h000)
               s_next.div = s_reg.div - 12'h001;
            else
            begin
               s_next.div  = s_reg.baud;
               s_next.half = s_reg.half + 4'h1;
               s_next.sck  = ~s_reg.sck;
               // sample on one edge, set up on the other
               if (lead != cpha)
               begin
                  word = lsb ? {s_reg.sdi_sync[1], s_reg.rsr[7:1]}
                             : {s_reg.rsr[6:0], s_reg.sdi_sync[1]};
                  s_next.rsr = word;
               end
               else if (cpha || s_reg.half != `USM_LAST_EDGE)
               begin
                  s_next.sdo = pick_bit(s_reg.tsr, lsb);
                  s_next.tsr = drop_bit(s_reg.tsr, lsb);
               end
               // end of an eight bit frame
               if (s_reg.half == `USM_LAST_EDGE)
               begin
                  rx_push = s_reg.control[`USM_CT_RXEN];
                  load    = 1'b1;
                  if (!s_reg.txfull)
                  begin
                     s_next.phase = usm_spi_pkg::USM_IDLE;
                     set_txc      = 1'b1;
                  end
               end
            end
         end
         default:
         begin
            s_next.phase = usm_spi_pkg::USM_IDLE;
         end
      endcase

      // buffered byte enters the free shifter at once
      // loading on the final edge keeps back to back
      // frames free of any idle gap; with phase zero
      // the first bit is put out ahead of the first edge
      if (load && s_reg.txfull && spi_on)
      begin
         s_next.phase  = usm_spi_pkg::USM_SHIFT;
         s_next.txfull = 1'b0;
         s_next.half   = 4'h0;
         s_next.div    = s_reg.baud;
         s_next.tsr    = s_reg.txbuf;
         if (!cpha)
         begin
            s_next.sdo = pick_bit(s_reg.txbuf, lsb);
            s_next.tsr = drop_bit(s_reg.txbuf, lsb);
         end
      end

      // set beats clear on transmit complete
      // an acknowledge or write one in the same cycle as
      // the end of a frame must not lose the event
      if (set_txc)
         s_next.txc = 1'b1;

      // receive buffer, read pops oldest first
      // rx0 holds the oldest byte and rx1 the next one;
      // the pop is applied before the push so a read and
      // a new byte in one cycle keep their order
      if (acc && !PWRITE_I && hit(PADDR_I, `USM_OFS_DATA)
          && s_reg.rxcnt != 2'h0)
      begin
         s_next.rx0 = s_reg.rx1;
         cnt        = cnt - 2'h1;
      end
      // newest byte is lost when both levels are full
      // older unread bytes stay as they were
      if (rx_push && cnt != `USM_RX_DEPTH)
      begin
         if (cnt == 2'h0)
            s_next.rx0 = word;
         else
            s_next.rx1 = word;
         cnt = cnt + 2'h1;
      end
      s_next.rxcnt = cnt;

      // receiver disable flushes the buffer
      // flush wins over a byte arriving in the same cycle
      if (!s_reg.control[`USM_CT_RXEN])
         s_next.rxcnt = 2'h0;
   end

   // ---------------------------------------------------------
   // state register
   // ---------------------------------------------------------
   // reset clears all state, then the fields with non
   // zero defaults get their values
   always_ff @(posedge CLOCK_I or negedge RSTN_I)
   begin
      if (!RSTN_I)
      begin
         s_reg          <= '0;
         s_reg.phase    <= usm_spi_pkg::USM_IDLE;
         s_reg.control  <= `USM_RST_CONTROL;
         s_reg.mode     <= `USM_RST_MODE;
         s_reg.baud     <= `USM_RST_BAUD;
         s_reg.sdo      <= 1'b1;
      end
      else
         s_reg <= s_next;
   end

   // ---------------------------------------------------------
   // outputs
   // ---------------------------------------------------------

   // apb answer, zero wait states
   // unmapped addresses answer with an error and
   // have no effect on any register
   assign PRDATA_O  = s_reg.prdata;
   assign PREADY_O  = 1'b1;
   assign PSLVERR_O = acc & ~mapped;

   // pin overrides, master only so no select input
   // the clock pin is driven only in spi master mode
   assign SDO_O     = s_reg.sdo;
   assign SDO_OE_O  = txen_eff;
   assign SDI_SEL_O = s_reg.control[`USM_CT_RXEN];
   assign XCK_O     = s_reg.sck;
   assign XCK_OE_O  = txen_eff & spi_on;

   // interrupt requests gated by the global flag
   // requests are levels and fall as soon as the flag,
   // its enable or the global flag goes low
   assign IRQ_RXC_O  = GLOBAL_IE_I & s_reg.control[`USM_CT_RXCIE]
                       & stat[`USM_ST_RXC];
   assign IRQ_TXC_O  = GLOBAL_IE_I & s_reg.control[`USM_CT_TXCIE]
                       & s_reg.txc;
   assign IRQ_UDRE_O = GLOBAL_IE_I & s_reg.control[`USM_CT_TX_EMPTY_IRQ_ENABLE]
                       & stat[`USM_ST_UDRE];

endmodule : usm_spi_top
